/* File: config_word_osc_select_test.sv */
// self-checking bench for the configuration word loader
`timescale 1ns/1ps
`default_nettype none
module config_word_osc_select_test;
    logic clock_i, rst_b_i, pm, pw, ep, ed, pon, bo, pin, oin, oout, oe;
    logic sreq, wwk, irq, dpn, ppn, bdo, rps, pun, wdg, rcm, iom, xtl;
    logic exm, drst, stp, slp, xoc;
    logic [1:0] bg;
    logic [2:0] osc;
    logic [13:0] pa, pd, rd, w, nv, r;
    logic [10:0] cf_q[$];
    logic [1:0] er_q[$];
    integer err_total, n_tests, seed, i, k, n, o, p;
    cwos_config_loader #(.POWERUP_CYCLES(20), .OST_CYCLES(8))
    u_cwos_config_loader (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .prog_mode_i(pm), .prog_addr_i(pa), .prog_write_i(pw),
        .prog_wdata_i(pd), .prog_rdata_o(rd), .prog_erase_prog_o(ep),
        .prog_erase_data_o(ed), .power_on_i(pon), .brownout_i(bo),
        .reset_or_input_pin_i(pin), .osc_input_pin_i(oin),
        .osc_output_pin_o(oout), .osc_output_pin_oe_o(oe),
        .sleep_req_i(sreq), .watchdog_wake_i(wwk), .irq_enabled_i(irq),
        .bandgap_trim_o(bg), .data_protect_n_o(dpn),
        .program_protect_n_o(ppn), .brownout_detect_on_o(bdo),
        .reset_pin_select_o(rps), .powerup_delay_enable_n_o(pun),
        .watchdog_on_o(wdg), .osc_select_o(osc),
        .resistor_capacitor_mode_o(rcm), .internal_osc_mode_o(iom),
        .crystal_mode_o(xtl), .external_clock_mode_o(exm),
        .ext_clock_on_input_o(xoc), .device_reset_o(drst),
        .internal_osc_stop_o(stp), .sleeping_o(slp));
    cwos_programmer_model u_cwos_programmer_model (.clock_i(clock_i),
        .prog_mode_o(pm), .prog_addr_o(pa), .prog_write_o(pw),
        .prog_wdata_o(pd), .prog_rdata_i(rd));
    ////////////////////////////////////////////////////////////////////
    // 250 MHz core clock
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // compare and count
    task check(input logic [15:0] got, input logic [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // count reset cycles until the device runs, then check the modes
    task wait_run(input integer lo, input integer hi);
    begin
        n = 0;
        do
        begin
            @(negedge clock_i);
            n = n + 1;
        end while (drst !== 1'b0 && n < 200);
        check(n >= lo && n <= hi, 1'b1);
        @(negedge clock_i);
        check({rcm, iom, xtl, exm, oe}, {w[2:1] == 2'h3, w[2:1] == 2'h2,
            w[2:0] < 3'h3, w[2:0] == 3'h3, w[2] & w[0]});
    end
    endtask
    // hold brown-out or the reset pin for two cycles, then restart
    task bump(input integer s);
    begin
        @(posedge clock_i) {bo, pin} <= (s != 0) ? 2'h3 : 2'h0;
        repeat (2) @(negedge clock_i);
        check({drst, stp}, (s != 0) ? {w[6], 1'b0}
            : {w[5], w[5] & w[2]});
        @(posedge clock_i) {bo, pin} <= 2'h1;
        if ((s != 0) ? w[6] : w[5])
        begin
            cf_q.push_back({nv[13:12], nv[8:0]});
            wait_run(0, o + ((s != 0) ? 28 : 8));
        end
    end
    endtask
    // results: settings at each reset exit, erase pulses as they occur
    always @(negedge drst)
        if (rst_b_i === 1'b1 && cf_q.size() > 0)
            check({bg, dpn, ppn, bdo, rps, pun, wdg, osc},
                cf_q.pop_front());
    always @(negedge clock_i)
        if (ep | ed)
            check({ep, ed}, (er_q.size() > 0) ? er_q.pop_front()
                : 2'h0);
    // hang guard, far above the expected run length
    initial
    begin
        #40000;
        err_total = err_total + 1;
        end_of_test;
    end
    // main sequence
    initial
    begin
        err_total = 0;
        n_tests = 0;
        seed = 32'h0095;
        {rst_b_i, pon, bo, pin, oin, sreq, wwk, irq} = 8'h10;
        nv = 14'h31ff;
        w = nv;
        o = 0;
        cf_q.push_back(11'h7ff);
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        wait_run(0, 8);
        u_cwos_programmer_model.read_word(14'h2007, 1'b1, r);
        check(r, nv);
        for (i = 0; i < 8; i = i + 1)
        begin
            w = $random(seed);
            w[6:0] = {~i[0], ~i[1], i[0], i[2], i[2:0]};
            o = (w[2:0] < 3'h3) ? 8 : 0;
            p = w[4] ? 0 : 20;
            if ((w[8] & ~nv[8]) | (w[7] & ~nv[7]))
                er_q.push_back({w[7] & ~nv[7], w[8] & ~nv[8]});
            u_cwos_programmer_model.write_word(w);
            nv = w & 14'h31ff;
            u_cwos_programmer_model.read_word(14'h2007, 1'b1, r);
            check(r, nv);
            u_cwos_programmer_model.read_word(14'h2006, 1'b1, r);
            check(r, 14'h0000);
            u_cwos_programmer_model.read_word(14'h2007, 1'b0, r);
            check(r, 14'h0000);
            cf_q.push_back({nv[13:12], nv[8:0]});
            @(posedge clock_i) pon <= 1'b1;
            @(posedge clock_i) pon <= 1'b0;
            wait_run(p + o, p + o + 8);
            repeat (8) @(posedge clock_i) oin <= $random(seed);
            repeat (2) @(negedge clock_i);
            check(xoc, (w[2:0] < 3'h3) & oin);
            bump(0);
            bump(1);
        end
        // last word has the watchdog on: wake by interrupt, then watchdog
        for (k = 0; k < 2; k = k + 1)
        begin
            @(posedge clock_i) sreq <= 1'b1;
            @(posedge clock_i) sreq <= 1'b0;
            repeat (2) @(negedge clock_i);
            check(slp, 1'b1);
            @(posedge clock_i) {irq, wwk} <= (k == 0) ? 2'h2 : 2'h1;
            repeat (3) @(negedge clock_i);
            check(slp, 1'b0);
            @(posedge clock_i) {irq, wwk} <= 2'h0;
        end
        check(er_q.size() + cf_q.size(), 16'h0000);
        end_of_test;
    end
endmodule // config_word_osc_select_test
`default_nettype wire

/* File: cwos_config_loader.v */
// configuration word store, decode, reset timers, clock out and wake logic
`timescale 1ns/1ps
`default_nettype none
`include "cwos_regs.vh"
module cwos_config_loader #(
    parameter POWERUP_CYCLES = `CWOS_POWERUP_DELAY_MS *
        `CWOS_CLOCK_MHZ * 1000,
    parameter OST_CYCLES = `CWOS_OST_CYCLES,
    parameter TW = 25
) (
    // clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // programming port
    input wire prog_mode_i,
    input wire [13:0] prog_addr_i,
    input wire prog_write_i,
    input wire [13:0] prog_wdata_i,
    output reg [13:0] prog_rdata_o,
    output wire prog_erase_prog_o,
    output wire prog_erase_data_o,
    // power and reset events
    input wire power_on_i,
    input wire brownout_i,
    // pins
    input wire reset_or_input_pin_i,
    input wire osc_input_pin_i,
    output reg osc_output_pin_o,
    output wire osc_output_pin_oe_o,
    // sleep and wake sources
    input wire sleep_req_i,
    input wire watchdog_wake_i,
    input wire irq_enabled_i,
    // decoded settings
    output reg [1:0] bandgap_trim_o,
    output reg data_protect_n_o,
    output reg program_protect_n_o,
    output reg brownout_detect_on_o,
    output reg reset_pin_select_o,
    output reg powerup_delay_enable_n_o,
    output reg watchdog_on_o,
    output reg [2:0] osc_select_o,
    output reg resistor_capacitor_mode_o,
    output reg internal_osc_mode_o,
    output reg crystal_mode_o,
    output reg external_clock_mode_o,
    output reg ext_clock_on_input_o,
    // device state
    output wire device_reset_o,
    output wire internal_osc_stop_o,
    output reg sleeping_o
);
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function is_cfg_space;
        input [13:0] a;
        begin
            is_cfg_space = (a >= `CWOS_CFG_SPACE_LO) &&
                (a <= `CWOS_CFG_SPACE_HI);
        end
    endfunction

    function rc_or_int;
        input [2:0] m;
        begin
            rc_or_int = m[2];
        end
    endfunction

    // the three crystal codes; external clock code excluded
    function is_crystal;
        input [2:0] m;
        begin
            is_crystal = !m[2] && (m != `CWOS_OSC_EXT_CLOCK);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // non-volatile word, erased state is all ones in the implemented bits
    reg [13:0] nv_word_reg;
    reg [13:0] nv_word_next;
    reg erase_prog_reg;
    reg erase_data_reg;
    wire cfg_hit;
    wire cfg_write;

    // writes only in programming mode and only inside config space
    assign cfg_hit = prog_mode_i && is_cfg_space(prog_addr_i);
    assign cfg_write = cfg_hit && prog_write_i &&
        (prog_addr_i == `CWOS_CFG_ADDR);

    // unimplemented bits forced to zero on every store
    always @*
    begin
        nv_word_next = nv_word_reg;
        if (cfg_write)
            nv_word_next = prog_wdata_i & `CWOS_CFG_IMPL_MASK;
    end

    // nvm content is not reset by the pin; reset leaves it erased-blank
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            nv_word_reg <= `CWOS_CFG_ERASED & `CWOS_CFG_IMPL_MASK;
        else
            nv_word_reg <= nv_word_next;
    end

    // protection going from on to off wipes the protected array
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            erase_prog_reg <= 1'b0;
            erase_data_reg <= 1'b0;
        end
        else
        begin
            erase_data_reg <= cfg_write &&
                !nv_word_reg[`CWOS_DATA_PROT_BIT] &&
                prog_wdata_i[`CWOS_DATA_PROT_BIT];
            erase_prog_reg <= cfg_write &&
                !nv_word_reg[`CWOS_PROG_PROT_BIT] &&
                prog_wdata_i[`CWOS_PROG_PROT_BIT];
        end
    end
    assign prog_erase_prog_o = erase_prog_reg;
    assign prog_erase_data_o = erase_data_reg;

    // readback: config word at its address, rest of space reads zero
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prog_rdata_o <= 14'h0000;
        else if (cfg_hit && prog_addr_i == `CWOS_CFG_ADDR)
            prog_rdata_o <= nv_word_reg;
        else
            prog_rdata_o <= 14'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sequencing, one-hot
    localparam ST_LOAD = 4'h1;
    localparam ST_POWERUP = 4'h2;
    localparam ST_START = 4'h4;
    localparam ST_RUN = 4'h8;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg pwr_start;
    reg ost_start;
    wire pwr_busy;
    wire ost_busy;
    wire ext_reset;
    wire latch_cfg;
    wire [2:0] nv_osc;
    reg from_power_reg;

    // external reset only counts when the pin is selected as reset
    assign ext_reset = reset_pin_select_o && !reset_or_input_pin_i;
    assign nv_osc = nv_word_reg[`CWOS_OSC_HI:`CWOS_OSC_LO];

    // a pin reset must not replay the 72 ms delay, so remember the cause
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            from_power_reg <= 1'b1;
        else if (power_on_i)
            from_power_reg <= 1'b1;
        else if (ext_reset)
            from_power_reg <= 1'b0;
    end

    always @*
    begin
        state_next = state_reg;
        pwr_start = 1'b0;
        ost_start = 1'b0;
        case (state_reg)
            ST_LOAD:
            begin
                // power-up timer runs only after power-on or brown-out
                if ((!nv_word_reg[`CWOS_POWERUP_BIT] && from_power_reg) ||
                    brownout_i)
                begin
                    state_next = ST_POWERUP;
                    pwr_start = 1'b1;
                end
                else
                begin
                    state_next = ST_START;
                    ost_start = is_crystal(nv_osc);
                end
            end
            ST_POWERUP:
                if (!pwr_busy)
                begin
                    state_next = ST_START;
                    ost_start = is_crystal(osc_select_o);
                end
            ST_START:
                if (!ost_busy)
                    state_next = ST_RUN;
            ST_RUN:
                state_next = ST_RUN;
            default:
                state_next = ST_LOAD;
        endcase
        // brown-out with detection on restarts with the 72 ms hold
        if (brownout_detect_on_o && brownout_i)
        begin
            state_next = ST_POWERUP;
            pwr_start = 1'b1;
            ost_start = 1'b0;
        end
        else if (power_on_i || ext_reset)
            state_next = ST_LOAD;
    end

    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_reg <= ST_LOAD;
        else
            state_reg <= state_next;
    end

    // brown-out enable plus brown-out starts this timer whatever the power-up enable bit
    cwos_delay_timer #(.WIDTH(TW)) u_powerup_delay_timer (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .start_i(pwr_start),
        .length_i(POWERUP_CYCLES[TW-1:0]),
        .busy_o(pwr_busy)
    );

    // stands in for crystal stabilisation detection
    cwos_delay_timer #(.WIDTH(TW)) u_osc_startup_timer (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .start_i(ost_start),
        .length_i(OST_CYCLES[TW-1:0]),
        .busy_o(ost_busy)
    );

    assign device_reset_o = (state_reg != ST_RUN);
    assign latch_cfg = (state_reg == ST_LOAD);

    ////////////////////////////////////////////////////////////////////////
    // settings latched while in the load state, frozen while running
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bandgap_trim_o <= 2'h3;
            data_protect_n_o <= 1'b1;
            program_protect_n_o <= 1'b1;
            brownout_detect_on_o <= 1'b1;
            reset_pin_select_o <= 1'b1;
            powerup_delay_enable_n_o <= 1'b1;
            watchdog_on_o <= 1'b1;
            osc_select_o <= `CWOS_OSC_RC_DIVIDED_CLOCK_OUT;
        end
        else if (latch_cfg)
        begin
            bandgap_trim_o <= nv_word_reg[`CWOS_BG_HI:`CWOS_BG_LO];
            data_protect_n_o <= nv_word_reg[`CWOS_DATA_PROT_BIT];
            program_protect_n_o <= nv_word_reg[`CWOS_PROG_PROT_BIT];
            brownout_detect_on_o <= nv_word_reg[`CWOS_BROWNOUT_BIT];
            reset_pin_select_o <= nv_word_reg[`CWOS_RESET_PIN_BIT];
            powerup_delay_enable_n_o <= nv_word_reg[`CWOS_POWERUP_BIT];
            watchdog_on_o <= nv_word_reg[`CWOS_WATCHDOG_BIT];
            osc_select_o <= nv_word_reg[`CWOS_OSC_HI:`CWOS_OSC_LO];
        end
    end

    // mode decode from the latched select
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            resistor_capacitor_mode_o <= 1'b0;
            internal_osc_mode_o <= 1'b0;
            crystal_mode_o <= 1'b0;
            external_clock_mode_o <= 1'b0;
            ext_clock_on_input_o <= 1'b0;
        end
        else
        begin
            resistor_capacitor_mode_o <= (osc_select_o[2:1] == 2'h3);
            internal_osc_mode_o <= (osc_select_o[2:1] == 2'h2);
            external_clock_mode_o <=
                (osc_select_o == `CWOS_OSC_EXT_CLOCK);
            crystal_mode_o <= is_crystal(osc_select_o);
            // a driven clock on the input pin is accepted in crystal modes
            ext_clock_on_input_o <= is_crystal(osc_select_o) &&
                osc_input_pin_i;
        end
    end

    // internal oscillator halted while external reset is held
    assign internal_osc_stop_o = ext_reset && rc_or_int(osc_select_o);

    ////////////////////////////////////////////////////////////////////////
    // clock out: core clock divided by four on the output pin
    reg [1:0] div_reg;
    wire divided_clock_out_sel;
    assign divided_clock_out_sel = (osc_select_o == `CWOS_OSC_RC_DIVIDED_CLOCK_OUT) ||
        (osc_select_o == `CWOS_OSC_INT_DIVIDED_CLOCK_OUT);
    assign osc_output_pin_oe_o = divided_clock_out_sel && !device_reset_o;

    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            div_reg <= 2'h0;
            osc_output_pin_o <= 1'b0;
        end
        else
        begin
            // toggle every second cycle gives a period of four cycles
            div_reg <= (div_reg == `CWOS_CLKDIV_HALF) ? 2'h0 :
                div_reg + 2'h1;
            if (div_reg == `CWOS_CLKDIV_HALF)
                osc_output_pin_o <= !osc_output_pin_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep: entered on request, left on external reset, device reset, watchdog wake or interrupt
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sleeping_o <= 1'b0;
        else if (ext_reset || device_reset_o ||
            (watchdog_wake_i && watchdog_on_o) || irq_enabled_i)
            sleeping_o <= 1'b0;
        else if (sleep_req_i)
            sleeping_o <= 1'b1;
    end
    // watchdog counter itself lives in its own rc domain outside this block
endmodule // cwos_config_loader
`default_nettype wire

/* File: cwos_config_loader_monitor.sv */
// assertion checker for the configuration word loader
`timescale 1ns/1ps
`default_nettype none
module cwos_config_loader_monitor (
    // clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // programming port
    input wire prog_mode_i,
    input wire [13:0] prog_addr_i,
    input wire prog_write_i,
    input wire [13:0] prog_wdata_i,
    input wire [13:0] prog_rdata_o,
    input wire prog_erase_prog_o,
    input wire prog_erase_data_o,
    // pins and wake
    input wire reset_or_input_pin_i,
    input wire irq_enabled_i,
    input wire osc_output_pin_o,
    input wire osc_output_pin_oe_o,
    // settings and state
    input wire reset_pin_select_o,
    input wire [2:0] osc_select_o,
    input wire device_reset_o,
    input wire internal_osc_stop_o,
    input wire sleeping_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    // accepted writes that clear a protection
    wire wr_d = prog_mode_i && prog_write_i && prog_addr_i == 14'h2007
        && prog_wdata_i[8];
    wire wr_p = prog_mode_i && prog_write_i && prog_addr_i == 14'h2007
        && prog_wdata_i[7];
    ////////////////////////////////////////////////////////////////////
    // divided clock: a rising output stays high two cycles
    sequence s_rise;
        $rose(osc_output_pin_o) && osc_output_pin_oe_o ##1 osc_output_pin_oe_o;
    endsequence
    property p_unimpl;
        prog_rdata_o[11:9] == 3'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("bits 11-9 set");
    property p_lock;
        !prog_mode_i |=> prog_rdata_o == 14'h0000;
    endproperty
    a_lock: assert property (p_lock) else $error("read out of mode");
    property p_erase_d;
        prog_erase_data_o |-> $past(wr_d) ##1 !prog_erase_data_o;
    endproperty
    a_erase_d: assert property (p_erase_d) else $error("data erase");
    property p_erase_p;
        prog_erase_prog_o |-> $past(wr_p) ##1 !prog_erase_prog_o;
    endproperty
    a_erase_p: assert property (p_erase_p) else $error("prog erase");
    property p_static;
        !device_reset_o && !$past(device_reset_o) |-> $stable(osc_select_o);
    endproperty
    a_static: assert property (p_static) else $error("setting moved");
    property p_divided_clock_out;
        s_rise |-> osc_output_pin_o ##1 !osc_output_pin_o;
    endproperty
    a_divided_clock_out: assert property (p_divided_clock_out) else $error("clock out");
    property p_stop;
        internal_osc_stop_o |-> reset_pin_select_o && osc_select_o[2] &&
            !reset_or_input_pin_i;
    endproperty
    a_stop: assert property (p_stop) else $error("osc stop");
    property p_wake;
        sleeping_o && irq_enabled_i |-> ##[1:3] !sleeping_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
endmodule // cwos_config_loader_monitor
bind cwos_config_loader cwos_config_loader_monitor u_monitor (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .prog_mode_i(prog_mode_i),
    .prog_addr_i(prog_addr_i), .prog_write_i(prog_write_i),
    .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o),
    .prog_erase_prog_o(prog_erase_prog_o),
    .prog_erase_data_o(prog_erase_data_o),
    .reset_or_input_pin_i(reset_or_input_pin_i),
    .irq_enabled_i(irq_enabled_i), .osc_output_pin_o(osc_output_pin_o),
    .osc_output_pin_oe_o(osc_output_pin_oe_o),
    .reset_pin_select_o(reset_pin_select_o), .osc_select_o(osc_select_o),
    .device_reset_o(device_reset_o),
    .internal_osc_stop_o(internal_osc_stop_o), .sleeping_o(sleeping_o));
`default_nettype wire

/* File: cwos_delay_timer.v */
// one-shot reset-extension delay counter
`timescale 1ns/1ps
`default_nettype none
module cwos_delay_timer #(
    parameter WIDTH = 25
) (
    // clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // control
    input wire start_i,
    input wire [WIDTH-1:0] length_i,
    // status
    output wire busy_o
);
    reg [WIDTH-1:0] count_reg;
    // load on start, count down to zero; busy while nonzero
    always @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            count_reg <= {WIDTH{1'b0}};
        else if (start_i)
            count_reg <= length_i;
        else if (count_reg != {WIDTH{1'b0}})
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
    assign busy_o = start_i || (count_reg != {WIDTH{1'b0}});
endmodule // cwos_delay_timer
`default_nettype wire

/* File: cwos_programmer_model.sv */
// programmer model that drives the programming port of the loader
`timescale 1ns/1ps
`default_nettype none
module cwos_programmer_model (
    // clock
    input wire logic clock_i,
    // programming port
    output logic prog_mode_o,
    output logic [13:0] prog_addr_o,
    output logic prog_write_o,
    output logic [13:0] prog_wdata_o,
    input wire logic [13:0] prog_rdata_i
);
    // idle outside programming mode from time zero
    initial
    begin
        prog_mode_o = 1'b0;
        prog_addr_o = 14'h0000;
        prog_write_o = 1'b0;
        prog_wdata_o = 14'h0000;
    end
    // one write strobe; mode is raised only around the access
    task write_word(input logic [13:0] d);
    begin
        @(posedge clock_i);
        prog_mode_o <= 1'b1;
        prog_addr_o <= 14'h2007;
        prog_wdata_o <= d;
        prog_write_o <= 1'b1;
        @(posedge clock_i);
        prog_mode_o <= 1'b0;
        prog_write_o <= 1'b0;
        prog_wdata_o <= ~d; // stale data never looks valid
    end
    endtask
    // readback is registered, so the answer is taken two edges later
    task read_word(input logic [13:0] a, input logic m,
        output logic [13:0] r);
    begin
        @(posedge clock_i);
        prog_mode_o <= m;
        prog_addr_o <= a;
        repeat (2) @(posedge clock_i);
        r = prog_rdata_i;
        prog_mode_o <= 1'b0;
    end
    endtask
endmodule // cwos_programmer_model
`default_nettype wire

/* File: cwos_regs.vh */
// constants for the configuration word loader and its timers
`ifndef CWOS_REGS_VH
`define CWOS_REGS_VH
`define CWOS_CFG_ADDR 14'h2007
`define CWOS_CFG_SPACE_LO 14'h2000
`define CWOS_CFG_SPACE_HI 14'h3fff
`define CWOS_CFG_WIDTH 14
`define CWOS_CFG_ERASED 14'h3fff
`define CWOS_CFG_IMPL_MASK 14'h31ff
`define CWOS_BG_HI 13
`define CWOS_BG_LO 12
`define CWOS_DATA_PROT_BIT 8
`define CWOS_PROG_PROT_BIT 7
`define CWOS_BROWNOUT_BIT 6
`define CWOS_RESET_PIN_BIT 5
`define CWOS_POWERUP_BIT 4
`define CWOS_WATCHDOG_BIT 3
`define CWOS_OSC_HI 2
`define CWOS_OSC_LO 0
`define CWOS_OSC_RC_DIVIDED_CLOCK_OUT 3'h7
`define CWOS_OSC_RC_IO 3'h6
`define CWOS_OSC_INT_DIVIDED_CLOCK_OUT 3'h5
`define CWOS_OSC_INT_IO 3'h4
`define CWOS_OSC_EXT_CLOCK 3'h3
`define CWOS_OSC_HS 3'h2
`define CWOS_OSC_XT 3'h1
`define CWOS_OSC_LP 3'h0
`define CWOS_POWERUP_DELAY_MS 72
`define CWOS_CLOCK_MHZ 250
`define CWOS_OST_CYCLES 1024
`define CWOS_CLKDIV_HALF 2'h1
`endif
